// ==== bench/adcr_host_model.sv ====
// Host-side model that captures serial result frames and clocks slave reads.
`timescale 1ns/1ns
module adcr_host_model
  import adcr_pkg::*;
(
  input  wire logic      i_clk,
  input  wire adcr_ser_s i_ser,
  output logic           o_ext_clk,
  output logic [15:0]    o_word,
  output int             o_period,
  output int             o_since
);
  logic [15:0] shift_reg;
  logic        sclk_q;
  logic        mark_q;
  int          gap;
  logic        sclk_pin;
  logic        sdo_pin;

  // With no pull on these lines, an undriven pin reads as the inverse of
  // the last driven level, so a capture outside the enable shows up wrong.
  assign sclk_pin = i_ser.serial_result_clock_oe ?
                    i_ser.serial_result_clock : !i_ser.serial_result_clock;
  assign sdo_pin  = i_ser.serial_result_out_oe ?
                    i_ser.serial_result_out : !i_ser.serial_result_out;

  initial begin
    o_ext_clk = 1'b0;
    sclk_q = 1'b0;
    mark_q = 1'b0;
    gap = 0;
    o_since = 0;
  end

  // The device changes data on the falling clock, so bits are taken on the
  // rising one, only while the marker is driven and high.
  always @(posedge i_clk) begin
    if (i_ser.frame_marker_oe && i_ser.frame_marker &&
        sclk_pin && !sclk_q) begin
      shift_reg <= {shift_reg[14:0], sdo_pin};
      o_period <= gap;
      gap <= 1;
    end else begin
      gap <= gap + 1;
    end
    if (mark_q && !i_ser.frame_marker) begin
      o_word <= shift_reg;
      o_since <= 0;
    end else begin
      o_since <= o_since + 1;
    end
    sclk_q <= sclk_pin;
    mark_q <= i_ser.frame_marker;
  end

  // Slow slave read; the clock stands low between words.
  task automatic slave_read(output logic [15:0] w);
    for (int b = 0; b < 16; b++) begin
      repeat (4) @(negedge i_clk);
      o_ext_clk = 1'b1;
      w = {w[14:0], sdo_pin};
      repeat (4) @(negedge i_clk);
      o_ext_clk = 1'b0;
    end
  endtask : slave_read
endmodule : adcr_host_model

// ==== bench/adcr_top_tb.sv ====
// Self-checking bench for the conversion read-out block.
`timescale 1ns/1ns
module adcr_top_tb;
  import adcr_pkg::*;
  logic        clk;
  logic        rst_b;
  logic        strobe_n;
  logic        cs_n;
  logic        ext_clk;
  logic [15:0] result;
  logic [15:0] o_data;
  logic [15:0] rd;
  logic [15:0] frame_word;
  logic        busy;
  logic        full;
  logic        data_oe;
  adcr_cfg_s   cfg;
  adcr_ser_s   ser;
  int          fails;
  int          checked;
  int          cyc;
  int          m;
  int          w;
  int          period;
  int          since;
  logic [15:0] d;
  int          widths[4] = '{19, 24, 29, 29};
  int          halves[4] = '{1, 1, 2, 3};

  adcr_top i_adcr_top (
    .i_clk_sys          (clk),
    .i_rst_b            (rst_b),
    .i_clk_en           (1'b1),
    .i_cfg              (cfg),
    .i_convert_strobe_n (strobe_n),
    .i_chip_select_n    (cs_n),
    .i_ext_serial_clock (ext_clk),
    .i_result           (result),
    .o_busy             (busy),
    .o_fifo_full        (full),
    .o_data             (o_data),
    .o_data_oe          (data_oe),
    .o_ser              (ser)
  );

  adcr_host_model i_adcr_host_model (
    .i_clk     (clk),
    .i_ser     (ser),
    .o_ext_clk (ext_clk),
    .o_word    (frame_word),
    .o_period  (period),
    .o_since   (since)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic complete_run;
    $display("checks %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  task automatic compare(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t ns: saw %0h, want %0h", $time, seen, exp);
    end
  endtask : compare

  // Strobe held one cycle, well above the minimum pulse width.
  task automatic convert(input logic [15:0] val, output int width,
                         output logic [15:0] last);
    int n;
    result = val;
    strobe_n = 1'b0;
    @(negedge clk);
    strobe_n = 1'b1;
    width = 0;
    for (n = 0; n < 8 && busy !== 1'b1; n++) @(negedge clk);
    if (width == 0 && busy === 1'b1) compare(n <= 4, 1'b1);
    while (busy === 1'b1 && width < 400) begin
      last = o_data;
      @(negedge clk);
      width++;
    end
  endtask : convert

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fails++;
      complete_run();
    end
  end

  initial begin
    cyc = 0;
    fails = 0;
    checked = 0;
    rst_b = 1'b0;
    strobe_n = 1'b1;
    cs_n = 1'b0;
    result = 16'h0000;
    cfg = '{CM_FAST, RM_PARALLEL, 2'h0};
    repeat (20) @(negedge clk);
    compare({busy, data_oe, ser}, 32'h0);
    rst_b = 1'b1;
    repeat (6) @(negedge clk);
    for (m = 0; m < 4; m++) begin
      cfg.conv_mode = adcr_conv_e'(m[1:0]);
      convert(16'hA5C0 + 16'(m), w, d);
      compare(w, widths[m]);
      compare(d, 16'hA5C0 + 16'(m));
      compare(o_data, 16'hA5C0 + 16'(m));
      compare(data_oe, 1'b1);
      repeat (20) @(negedge clk);
    end
    cs_n = 1'b1;
    repeat (5) @(negedge clk);
    compare(data_oe, 1'b0);
    cfg = '{CM_FAST, RM_MST_AFTER, 2'h0};
    cs_n = 1'b0;
    for (m = 0; m < 4; m++) begin
      cfg.serial_clock_divider = m[1:0];
      repeat (5) @(negedge clk);
      convert(16'h3C00 + 16'(m), w, d);
      compare(frame_word, 16'h3C00 + 16'(m));
      compare(period, 2 * halves[m]);
      compare(since, 0);
      repeat (20) @(negedge clk);
    end
    // Words pile up with the select high until the buffer refuses starts.
    cs_n = 1'b1;
    cfg.read_mode = RM_SLAVE;
    for (m = 0; m < 4; m++) begin
      convert(16'h1200 + 16'(m), w, d);
      repeat (20) @(negedge clk);
    end
    compare(full, 1'b1);
    compare(ser.serial_result_out_oe, 1'b0);
    convert(16'hFFFF, w, d);
    compare(w, 0);
    cs_n = 1'b0;
    for (m = 0; m < 4; m++) begin
      repeat (8) @(negedge clk);
      i_adcr_host_model.slave_read(rd);
      compare(rd, 16'h1200 + 16'(m));
    end
    repeat (8) @(negedge clk);
    compare(full, 1'b0);
    // The shortest serial clock lets the frame end within the wait below.
    cfg = '{CM_FAST, RM_MST_DURING, 2'h0};
    convert(16'h8421, w, d);
    repeat (20) @(negedge clk);
    // The buffer was empty at the launch point, so no frame went out.
    compare(frame_word, 16'h3C03);
    convert(16'h7E18, w, d);
    repeat (40) @(negedge clk);
    compare(frame_word, 16'h8421);
    complete_run();
  end
endmodule : adcr_top_tb

// ==== core/adcr_cfg.svh ====
// Timing and layout constants of the conversion read-out block.
`ifndef ADCR_CFG_SVH
`define ADCR_CFG_SVH
`define ADCR_CLK_HZ 20000000
`define ADCR_CLK_NS (1000000000 / `ADCR_CLK_HZ)
// Longest time to cycles: round down, never below one cycle.
`define ADCR_DN(ns) ((((ns) / `ADCR_CLK_NS) < 1) ? 1 : \
  ((ns) / `ADCR_CLK_NS))
// Least time to cycles: round up, never below one cycle.
`define ADCR_UP(ns) (((((ns) + `ADCR_CLK_NS - 1) / `ADCR_CLK_NS) < 1) ? \
  1 : (((ns) + `ADCR_CLK_NS - 1) / `ADCR_CLK_NS))
`define ADCR_WORD_BITS 16
`define ADCR_FIFO_DEPTH 4
`define ADCR_BUSY_RISE_NS 35
`define ADCR_BUSY_RISE_CYC `ADCR_DN(`ADCR_BUSY_RISE_NS)
`define ADCR_BUSY_F_NS 950
`define ADCR_BUSY_N_NS 1250
`define ADCR_BUSY_L_NS 1450
`define ADCR_BUSY_F_CYC `ADCR_DN(`ADCR_BUSY_F_NS)
`define ADCR_BUSY_N_CYC `ADCR_DN(`ADCR_BUSY_N_NS)
`define ADCR_BUSY_L_CYC `ADCR_DN(`ADCR_BUSY_L_NS)
`define ADCR_DATA_F_NS 910
`define ADCR_DATA_N_NS 1160
`define ADCR_DATA_L_NS 1410
`define ADCR_DATA_F_CYC `ADCR_DN(`ADCR_DATA_F_NS)
`define ADCR_DATA_N_CYC `ADCR_DN(`ADCR_DATA_N_NS)
`define ADCR_DATA_L_CYC `ADCR_DN(`ADCR_DATA_L_NS)
`define ADCR_SYNC_F_NS 65
`define ADCR_SYNC_N_NS 315
`define ADCR_SYNC_L_NS 560
`define ADCR_SYNC_F_CYC `ADCR_DN(`ADCR_SYNC_F_NS)
`define ADCR_SYNC_N_CYC `ADCR_DN(`ADCR_SYNC_N_NS)
`define ADCR_SYNC_L_CYC `ADCR_DN(`ADCR_SYNC_L_NS)
`define ADCR_SCLK_HI0_NS 15
`define ADCR_SCLK_HI1_NS 30
`define ADCR_SCLK_HI2_NS 60
`define ADCR_SCLK_HI3_NS 120
`define ADCR_HALF0_CYC `ADCR_UP(`ADCR_SCLK_HI0_NS)
`define ADCR_HALF1_CYC `ADCR_UP(`ADCR_SCLK_HI1_NS)
`define ADCR_HALF2_CYC `ADCR_UP(`ADCR_SCLK_HI2_NS)
`define ADCR_HALF3_CYC `ADCR_UP(`ADCR_SCLK_HI3_NS)
`endif

// ==== core/adcr_pkg.sv ====
// Types shared by the conversion read-out block.
package adcr_pkg;
  typedef logic [7:0] adcr_cnt_t;
  typedef enum logic [1:0] {
    CM_FAST   = 2'h0,
    CM_NORMAL = 2'h1,
    CM_LOWPWR = 2'h2
  } adcr_conv_e;
  typedef enum logic [1:0] {
    RM_PARALLEL   = 2'h0,
    RM_MST_DURING = 2'h1,
    RM_MST_AFTER  = 2'h2,
    RM_SLAVE      = 2'h3
  } adcr_read_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_CONV = 2'h1,
    ST_FIN  = 2'h2,
    ST_XFER = 2'h3
  } adcr_state_e;
  typedef struct packed {
    adcr_conv_e conv_mode;
    adcr_read_e read_mode;
    logic [1:0] serial_clock_divider;
  } adcr_cfg_s;
  typedef struct packed {
    logic serial_result_clock;
    logic serial_result_clock_oe;
    logic frame_marker;
    logic frame_marker_oe;
    logic serial_result_out;
    logic serial_result_out_oe;
  } adcr_ser_s;
endpackage : adcr_pkg

// ==== core/adcr_top.sv ====
// Result FIFO and conversion sequencer with parallel and serial read-out.
`timescale 1ns/1ns
`include "adcr_cfg.svh"

module adcr_fifo #(
  parameter int WIDTH = `ADCR_WORD_BITS,
  parameter int DEPTH = `ADCR_FIFO_DEPTH
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_en,
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  output logic                  o_out_valid,
  output logic      [WIDTH-1:0] o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = (DEPTH < 2) ? 1 : $clog2(DEPTH);
  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("adcr_fifo: DEPTH must be a power of two, at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      cnt_reg;
  logic             wr;
  logic             rd;

  assign o_in_ready  = cnt_reg != (AW+1)'(DEPTH);
  assign o_out_valid = cnt_reg != '0;
  assign o_out_data  = mem_reg[rd_ptr_reg];
  assign wr          = i_in_valid && o_in_ready;
  assign rd          = o_out_valid && i_out_ready;

  always_ff @(posedge i_clk) begin
    if (i_en && wr) begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg    <= '0;
    end else if (i_en) begin
      if (wr) begin
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
      if (rd) begin
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      end
      if (wr && !rd) begin
        cnt_reg <= cnt_reg + (AW+1)'(1);
      end else if (rd && !wr) begin
        cnt_reg <= cnt_reg - (AW+1)'(1);
      end
    end
  end
endmodule : adcr_fifo

// Functional notes
// RL1: Host spaces convert strobes by mode minimum.
// RL2: Fastest mode needs next conversion within 1 ms.
// RL3: Busy rises promptly after convert strobe falls.
// RL4: Busy and conversion bounded per mode.
// RL5: Busy falls after conversion completes, not before.
// RL6: Parallel data valid by per-mode deadline.
// RL7: Parallel data valid before busy falls.
// RL8: During-convert frame starts at per-mode delay.
// RL9: After-convert frame starts after conversion ends.
// RL10: After-convert busy falls just after frame ends.
// RL11: Divider code sets serial clock period.
// RL12: After-convert busy width grows with divider.
// RL13: Gap between frame start and first edge.
// RL14: Frame marker held after last clock edge.
// RL15: Chip select low starts serial clock drive.
// RL16: Chip select high releases serial outputs.
// RL17: Result readable right after its own conversion; in during-convert mode it goes out at the next conversion's launch point.
// RL18: Each result is one sixteen-bit word.
// RL19: Sixteen bits shifted per frame, one per clock.
// RL20: Host strobe and reset pulses at least 10 ns.
module adcr_top
  import adcr_pkg::*;
#(
  parameter int DATA_W     = `ADCR_WORD_BITS,
  parameter int FIFO_DEPTH = `ADCR_FIFO_DEPTH
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst_b,
  input  wire logic              i_clk_en,
  input  wire adcr_cfg_s         i_cfg,
  input  wire logic              i_convert_strobe_n,
  input  wire logic              i_chip_select_n,
  input  wire logic              i_ext_serial_clock,
  input  wire logic [DATA_W-1:0] i_result,
  output logic                   o_busy,
  output logic                   o_fifo_full,
  output logic      [DATA_W-1:0] o_data,
  output logic                   o_data_oe,
  output adcr_ser_s              o_ser
);
  generate
    if (DATA_W < 2 || DATA_W > 32) begin : g_bad_width
      $error("adcr_top: DATA_W must lie between 2 and 32");
    end
  endgenerate

  function automatic adcr_cnt_t busy_max(adcr_conv_e m);
    case (m)
      CM_FAST:   busy_max = adcr_cnt_t'(`ADCR_BUSY_F_CYC);
      CM_NORMAL: busy_max = adcr_cnt_t'(`ADCR_BUSY_N_CYC);
      default:   busy_max = adcr_cnt_t'(`ADCR_BUSY_L_CYC);
    endcase
  endfunction : busy_max

  function automatic adcr_cnt_t data_max(adcr_conv_e m);
    case (m)
      CM_FAST:   data_max = adcr_cnt_t'(`ADCR_DATA_F_CYC);
      CM_NORMAL: data_max = adcr_cnt_t'(`ADCR_DATA_N_CYC);
      default:   data_max = adcr_cnt_t'(`ADCR_DATA_L_CYC);
    endcase
  endfunction : data_max

  function automatic adcr_cnt_t sync_at(adcr_conv_e m);
    case (m)
      CM_FAST:   sync_at = adcr_cnt_t'(`ADCR_SYNC_F_CYC);
      CM_NORMAL: sync_at = adcr_cnt_t'(`ADCR_SYNC_N_CYC);
      default:   sync_at = adcr_cnt_t'(`ADCR_SYNC_L_CYC);
    endcase
  endfunction : sync_at

  function automatic adcr_cnt_t half_of(logic [1:0] d);
    case (d)
      2'h0:    half_of = adcr_cnt_t'(`ADCR_HALF0_CYC);
      2'h1:    half_of = adcr_cnt_t'(`ADCR_HALF1_CYC);
      2'h2:    half_of = adcr_cnt_t'(`ADCR_HALF2_CYC);
      default: half_of = adcr_cnt_t'(`ADCR_HALF3_CYC);
    endcase
  endfunction : half_of

  logic              rst_s1_reg;
  logic              rst_q;
  logic [2:0]        pin_s1_reg;
  logic [2:0]        pin_s2_reg;
  logic [2:0]        pin_s3_reg;
  adcr_state_e       st_reg;
  adcr_cnt_t         cnt_reg;
  adcr_conv_e        mode_reg;
  logic              busy_reg;
  logic [DATA_W-1:0] data_reg;
  logic              load_q;
  logic [DATA_W-1:0] sh_reg;
  logic              sh_active_reg;
  logic              sh_master_reg;
  logic              tail_reg;
  logic [5:0]        bit_cnt_reg;
  adcr_cnt_t         hc_reg;
  logic              sclk_reg;
  logic              sync_reg;
  logic              sync_d_reg;
  logic              sclk_oe_reg;
  logic              sync_oe_reg;
  logic              sdo_oe_reg;
  logic              data_oe_reg;
  logic              en;
  logic              start_edge;
  logic              cs_act;
  logic              ext_fall;
  logic              par;
  logic              master;
  logic              after;
  logic              start_ok;
  logic              push;
  logic              launch_ok;
  logic              drain_ready;
  logic              pop;
  logic              f_in_ready;
  logic              f_out_valid;
  logic [DATA_W-1:0] f_out_data;
  adcr_cnt_t         half;

  assign en = i_clk_en;

  // Reset is applied at once but released only on a clock edge.
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_s1_reg <= 1'b0;
      rst_q      <= 1'b0;
    end else if (en) begin
      rst_s1_reg <= 1'b1;
      rst_q      <= rst_s1_reg;
    end
  end

  // Pins: [0] convert strobe, [1] chip select, [2] external clock.
  always_ff @(posedge i_clk_sys or negedge rst_q) begin
    if (!rst_q) begin
      pin_s1_reg <= 3'h3;
      pin_s2_reg <= 3'h3;
      pin_s3_reg <= 3'h3;
    end else if (en) begin
      pin_s1_reg <= {i_ext_serial_clock, i_chip_select_n,
                     i_convert_strobe_n};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  assign start_edge = !pin_s2_reg[0] && pin_s3_reg[0];
  assign cs_act     = !pin_s2_reg[1];
  assign ext_fall   = !pin_s2_reg[2] && pin_s3_reg[2];
  assign par        = i_cfg.read_mode == RM_PARALLEL;
  assign after      = i_cfg.read_mode == RM_MST_AFTER;
  assign master     = after || i_cfg.read_mode == RM_MST_DURING;
  assign half       = half_of(i_cfg.serial_clock_divider);

  // Strobes while busy or with a full FIFO are ignored.  // see RL1
  assign start_ok = start_edge && st_reg == ST_IDLE && f_in_ready;
  assign push     = st_reg == ST_CONV && cnt_reg == '0;

  // Conversion: the count starts two short so data lands on the data deadline.
  always_ff @(posedge i_clk_sys or negedge rst_q) begin
    if (!rst_q) begin
      st_reg   <= ST_IDLE;
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
      mode_reg <= CM_FAST;
    end else if (en) begin
      case (st_reg)
        ST_IDLE: begin
          if (start_ok) begin
            st_reg   <= ST_CONV;
            busy_reg <= 1'b1; // see RL3
            mode_reg <= i_cfg.conv_mode;
            cnt_reg  <= data_max(i_cfg.conv_mode) - 8'h02; // see RL6
          end
        end
        ST_CONV: begin
          if (cnt_reg == '0) begin
            st_reg  <= ST_FIN;
            cnt_reg <= 8'h01; // see RL5
          end else begin
            cnt_reg <= cnt_reg - 8'h01; // see RL4
          end
        end
        ST_FIN: begin
          if (after) begin
            st_reg <= ST_XFER; // see RL12
          end else if (cnt_reg == '0) begin
            busy_reg <= 1'b0; // see RL7
            st_reg   <= ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        ST_XFER: begin
          // Without chip select no frame can end the conversion.
          if ((sync_d_reg && !sync_reg) || !cs_act) begin
            busy_reg <= 1'b0; // see RL10
            st_reg   <= ST_IDLE;
          end
        end
        default: st_reg <= ST_IDLE;
      endcase
    end
  end

  // The FIFO lets serial frames lag behind conversions.
  adcr_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk_sys),
    .i_rst_n     (rst_q),
    .i_en        (en),
    .i_in_valid  (push), // see RL17
    .i_in_data   (i_result),
    .o_in_ready  (f_in_ready),
    .o_out_valid (f_out_valid),
    .o_out_data  (f_out_data),
    .i_out_ready (drain_ready)
  );

  assign launch_ok = (i_cfg.read_mode == RM_SLAVE) || after ||
    (st_reg == ST_CONV && cnt_reg ==
     data_max(mode_reg) - 8'h01 - sync_at(mode_reg)); // see RL8
  assign drain_ready = par || (!sh_active_reg && cs_act && launch_ok);
  assign pop = f_out_valid && drain_ready; // see RL9

  always_ff @(posedge i_clk_sys or negedge rst_q) begin
    if (!rst_q) begin
      data_reg <= '0;
      load_q   <= 1'b0;
    end else if (en) begin
      load_q <= pop && par;
      if (pop && par) begin
        data_reg <= f_out_data; // see RL18
      end
    end
  end

  // Serial shifter, master (own clock) or slave (external clock).
  always_ff @(posedge i_clk_sys or negedge rst_q) begin
    if (!rst_q) begin
      sh_reg        <= '0;
      sh_active_reg <= 1'b0;
      sh_master_reg <= 1'b0;
      tail_reg      <= 1'b0;
      bit_cnt_reg   <= '0;
      hc_reg        <= '0;
      sclk_reg      <= 1'b0;
      sync_reg      <= 1'b0;
    end else if (en) begin
      if (pop && !par) begin
        sh_reg        <= f_out_data;
        sh_active_reg <= 1'b1;
        sh_master_reg <= master;
        sync_reg      <= master;
        tail_reg      <= 1'b0;
        bit_cnt_reg   <= '0;
        sclk_reg      <= 1'b0;
        hc_reg        <= half; // see RL13
      end else if (sh_active_reg && !cs_act) begin
        sh_active_reg <= 1'b0;
        sync_reg      <= 1'b0;
        sclk_reg      <= 1'b0;
      end else if (sh_active_reg && sh_master_reg) begin
        if (hc_reg != '0) begin
          hc_reg <= hc_reg - 8'h01;
        end else begin
          hc_reg <= half - 8'h01; // see RL11
          if (tail_reg) begin
            sync_reg      <= 1'b0; // see RL14
            sclk_reg      <= 1'b0;
            sh_active_reg <= 1'b0;
          end else if (!sclk_reg) begin
            sclk_reg <= 1'b1;
            if (bit_cnt_reg == 6'(DATA_W - 1)) begin
              tail_reg <= 1'b1; // see RL19
            end
          end else begin
            sclk_reg    <= 1'b0;
            sh_reg      <= sh_reg << 1;
            bit_cnt_reg <= bit_cnt_reg + 6'h01;
          end
        end
      end else if (sh_active_reg && ext_fall) begin
        sh_reg      <= sh_reg << 1;
        bit_cnt_reg <= bit_cnt_reg + 6'h01;
        if (bit_cnt_reg == 6'(DATA_W - 1)) begin
          sh_active_reg <= 1'b0; // see RL19
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_q) begin
    if (!rst_q) begin
      sync_d_reg  <= 1'b0;
      sclk_oe_reg <= 1'b0;
      sync_oe_reg <= 1'b0;
      sdo_oe_reg  <= 1'b0;
      data_oe_reg <= 1'b0;
    end else if (en) begin
      sync_d_reg  <= sync_reg;
      sclk_oe_reg <= cs_act && master; // see RL15
      sync_oe_reg <= cs_act && master; // see RL16
      sdo_oe_reg  <= cs_act && !par; // see RL16
      data_oe_reg <= cs_act && par;
    end
  end

  assign o_busy      = busy_reg;
  assign o_fifo_full = !f_in_ready;
  assign o_data      = data_reg;
  assign o_data_oe   = data_oe_reg;
  assign o_ser = '{serial_result_clock:    sclk_reg,
                   serial_result_clock_oe: sclk_oe_reg,
                   frame_marker:           sync_reg,
                   frame_marker_oe:        sync_oe_reg,
                   serial_result_out:      sh_reg[DATA_W-1],
                   serial_result_out_oe:   sdo_oe_reg};

  // Helper counters read only by the checks below.
  adcr_cnt_t busy_cnt;
  logic [5:0] rise_cnt;
  logic       sclk_q;
  always_ff @(posedge i_clk_sys or negedge rst_q) begin
    if (!rst_q) begin
      busy_cnt <= '0;
      rise_cnt <= '0;
      sclk_q   <= 1'b0;
    end else if (en) begin
      busy_cnt <= busy_reg ? busy_cnt + 8'h01 : 8'h00;
      sclk_q   <= sclk_reg;
      if (pop && !par) begin
        rise_cnt <= '0;
      end else if (sclk_reg && !sclk_q) begin
        rise_cnt <= rise_cnt + 6'h01;
      end
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!rst_q || !i_clk_en);

  AST_BUSY_RISE: assert property (start_ok |=> o_busy) // see RL3
    else $error("busy did not rise after convert strobe");
  AST_BUSY_MAX: assert property ( // see RL4
    o_busy && !after |-> busy_cnt < busy_max(mode_reg))
    else $error("busy held longer than the mode allows");
  AST_BUSY_AFTER_END: assert property (push |=> o_busy [*2]) // see RL5
    else $error("busy fell too soon after conversion end");
  AST_DATA_DEADLINE: assert property ( // see RL6
    load_q && o_busy |-> busy_cnt <= data_max(mode_reg))
    else $error("parallel data later than its deadline");
  AST_DATA_BEFORE_FALL: assert property ( // see RL7
    $fell(o_busy) && par && !after |-> $past(load_q))
    else $error("busy fell without data valid a cycle before");
  AST_FIRST_EDGE_GAP: assert property ( // see RL13
    $rose(sync_reg) |-> !sclk_reg [*2])
    else $error("serial clock edge too close to frame start");
  AST_SYNC_TAIL: assert property ( // see RL14
    $fell(sync_reg) && $past(cs_act) |-> $past(sclk_reg))
    else $error("frame marker dropped without tail after last edge");
  AST_FRAME_BITS: assert property ( // see RL19
    $fell(sync_reg) && $past(cs_act) |-> rise_cnt == 6'(DATA_W))
    else $error("frame did not carry a whole word");
  AST_CS_DRIVE: assert property ( // see RL15
    cs_act && master |=> o_ser.serial_result_clock_oe)
    else $error("serial clock not driven under chip select");
  AST_CS_RELEASE: assert property ( // see RL16
    !cs_act |=> !o_ser.frame_marker_oe && !o_ser.serial_result_out_oe
      && !o_ser.serial_result_clock_oe && !o_data_oe)
    else $error("serial outputs not released");
  AST_AFTER_BUSY: assert property ( // see RL10
    $fell(sync_reg) && st_reg == ST_XFER |=> !o_busy)
    else $error("busy not dropped after frame in after mode");

  COV_PARALLEL: cover property ($fell(o_busy) && par);
  COV_MASTER_FRAME: cover property ($fell(sync_reg) && after);
  COV_SLAVE_WORD: cover property (
    $fell(sh_active_reg) && !sh_master_reg && cs_act);
  COV_FIFO_FULL: cover property (!f_in_ready);
endmodule : adcr_top
